// ===== shared/sdi_pkg.sv
// constants and types for the servo drive fault interlock
package sdi_pkg;
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SC_TIME_MS = 10;
  localparam int unsigned SC_CYCLES = CLK_HZ / 1000 * SC_TIME_MS;
  localparam int unsigned SC_CNT_W = 24;
  // over-current threshold in percent of rated peak
  localparam int unsigned OC_PCT = 300;
  // widths
  localparam int unsigned CUR_W = 12;
  localparam int unsigned ANG_W = 12;
  localparam int unsigned IND_W = 8;
  localparam int unsigned BRK_TIME_W = 32;
  localparam int unsigned NUM_SW = 6;
  localparam int unsigned NUM_SECT = 6;
  localparam int unsigned SECT_W = 3;
  // one sixth of a turn in angle counts
  localparam logic [ANG_W-1:0] SECT_SPAN = 12'h2ab;
  // indicator colours
  localparam logic [IND_W-1:0] IND_GREEN_MASK = 8'h01;
  localparam logic [IND_W-1:0] IND_YELLOW_MASK = 8'h0e;
  localparam logic [IND_W-1:0] IND_RED_MASK = 8'hf0;
  // fault bit positions
  localparam int unsigned FLT_SC = 0;
  localparam int unsigned FLT_OV = 1;
  localparam int unsigned FLT_CONV_LV = 2;
  localparam int unsigned FLT_CTRL_LV = 3;
  localparam int unsigned FLT_SW = 4;
  localparam int unsigned FLT_W = 5;
  // ready relay state machine
  typedef enum logic [2:0] {
    SDI_RDY_WAIT_RST = 3'b001,
    SDI_RDY_CLOSED = 3'b010,
    SDI_RDY_FAULT = 3'b100
  } sdi_rdy_state_t;
endpackage

// ===== core/sdi_sync.sv
// three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/1ps
module sdi_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sdi_sync_st_t;

  sdi_sync_st_t st_q;
  sdi_sync_st_t st_d;

  // shift chain; a level changes once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule // sdi_sync

// ===== core/sdi_interlock.sv
// servo drive fault interlock: stage gating, ready relay, flags, brake
`timescale 1ns/1ps
module sdi_interlock (
  input wire logic clk,
  input wire logic sys_rst,
  // pins from the drive, asynchronous to clk
  input wire logic hw_enable_pin,
  input wire logic motor_temp_open_pin,
  input wire logic drive_temp_high_pin,
  input wire logic bus_overvolt_pin,
  input wire logic conv_logic_low_pin,
  input wire logic ctrl_logic_low_pin,
  input wire logic bus_high_pin,
  input wire logic fast_event_input,
  // phase current magnitude and rated peak, clk domain
  input wire logic [sdi_pkg::CUR_W-1:0] phase_current,
  input wire logic [sdi_pkg::CUR_W-1:0] rated_peak_current,
  // firmware controls
  input wire logic fw_enable,
  input wire logic fw_soft_fault,
  input wire logic fw_reset_pulse,
  input wire logic fw_brake_relay,
  input wire logic fw_cpu_running,
  input wire logic [sdi_pkg::IND_W-1:0] fw_indicator,
  input wire logic fw_brake_time_clear,
  // commutation inputs
  input wire logic [sdi_pkg::ANG_W-1:0] motor_angle,
  input wire logic [sdi_pkg::CUR_W-1:0] torque_cmd,
  input wire logic torque_neg,
  // outputs
  output logic stage_enable,
  output logic [sdi_pkg::NUM_SW-1:0] switch_on,
  output logic ready_relay,
  output logic conv_reset_pulse,
  output logic motor_temp_high,
  output logic drive_temp_high,
  output logic [sdi_pkg::FLT_W-1:0] fault_latched,
  output logic brake_relay,
  output logic dyn_brake_on,
  output logic [sdi_pkg::BRK_TIME_W-1:0] dyn_brake_time,
  output logic cpu_ok_led,
  output logic [sdi_pkg::IND_W-1:0] user_indicator,
  output logic fast_event_flag
);

  //--------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------
  localparam int unsigned NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;

  assign pin_raw = {fast_event_input, bus_high_pin, ctrl_logic_low_pin,
                    conv_logic_low_pin, bus_overvolt_pin,
                    drive_temp_high_pin, motor_temp_open_pin,
                    hw_enable_pin};

  sdi_sync #(
    .W(NPIN)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(pin_raw),
    .level_out(pin_lvl)
  );

  logic hw_en_s;
  logic mtemp_s;
  logic dtemp_s;
  logic ov_s;
  logic conv_lv_s;
  logic ctrl_lv_s;
  logic bus_hi_s;
  logic fev_s;

  assign hw_en_s = pin_lvl[0];
  assign mtemp_s = pin_lvl[1];
  assign dtemp_s = pin_lvl[2];
  assign ov_s = pin_lvl[3];
  assign conv_lv_s = pin_lvl[4];
  assign ctrl_lv_s = pin_lvl[5];
  assign bus_hi_s = pin_lvl[6];
  assign fev_s = pin_lvl[7];

  //--------------------------------------------------------------
  // helper functions
  //--------------------------------------------------------------
  // current above 300 percent of rated peak, widened to avoid overflow
  function automatic logic over_current(
    input logic [sdi_pkg::CUR_W-1:0] cur,
    input logic [sdi_pkg::CUR_W-1:0] peak
  );
    logic [sdi_pkg::CUR_W+8:0] lhs;
    logic [sdi_pkg::CUR_W+8:0] rhs;
    lhs = (sdi_pkg::CUR_W+9)'(cur) * (sdi_pkg::CUR_W+9)'(100);
    rhs = (sdi_pkg::CUR_W+9)'(peak)
          * (sdi_pkg::CUR_W+9)'(sdi_pkg::OC_PCT);
    return lhs > rhs;
  endfunction

  // angle to sixty-degree sector
  function automatic logic [sdi_pkg::SECT_W-1:0] sector_of(
    input logic [sdi_pkg::ANG_W-1:0] ang
  );
    logic [sdi_pkg::SECT_W-1:0] s;
    s = '0;
    for (int k = 1; k < sdi_pkg::NUM_SECT; k++) begin
      if (ang >= sdi_pkg::ANG_W'(k * int'(sdi_pkg::SECT_SPAN))) begin
        s = sdi_pkg::SECT_W'(k);
      end
    end
    return s;
  endfunction

  //--------------------------------------------------------------
  // state
  //--------------------------------------------------------------
  typedef struct packed {
    sdi_pkg::sdi_rdy_state_t rdy;
    logic [sdi_pkg::FLT_W-1:0] flt;
    logic [sdi_pkg::SC_CNT_W-1:0] sc_cnt;
    logic stage_en;
    logic relay;
    logic rst_pulse;
    logic mtemp;
    logic dtemp;
    logic brk_relay;
    logic dbrake;
    logic [sdi_pkg::BRK_TIME_W-1:0] brk_time;
    logic cpu_ok;
    logic [sdi_pkg::IND_W-1:0] ind;
    logic [sdi_pkg::NUM_SW-1:0] sw;
    logic fev;
  } sdi_state_t;

  sdi_state_t st_q;
  sdi_state_t st_d;

  logic [sdi_pkg::FLT_W-1:0] flt_now;
  logic [sdi_pkg::FLT_W-1:0] flt_next;
  logic oc_now;
  logic [sdi_pkg::SECT_W-1:0] sect;
  logic [sdi_pkg::NUM_SW-1:0] pattern;

  //--------------------------------------------------------------
  // next-state logic
  //--------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    oc_now = over_current(phase_current, rated_peak_current);
    flt_now = '0;
    flt_next = '0;
    sect = sector_of(motor_angle);
    pattern = '0;

    // short-circuit persistence timer
    if (oc_now) begin
      if (st_q.sc_cnt < sdi_pkg::SC_CNT_W'(sdi_pkg::SC_CYCLES)) begin
        st_d.sc_cnt = st_q.sc_cnt + 1'b1;
      end
    end else begin
      st_d.sc_cnt = '0;
    end

    // live fault conditions
    flt_now[sdi_pkg::FLT_SC] = oc_now &&
      (st_q.sc_cnt >= sdi_pkg::SC_CNT_W'(sdi_pkg::SC_CYCLES - 1));
    flt_now[sdi_pkg::FLT_OV] = ov_s;
    flt_now[sdi_pkg::FLT_CONV_LV] = conv_lv_s;
    flt_now[sdi_pkg::FLT_CTRL_LV] = ctrl_lv_s;
    flt_now[sdi_pkg::FLT_SW] = fw_soft_fault;

    // latch; reset clears only once no condition is present, set wins
    if (fw_reset_pulse && flt_now == '0) begin
      flt_next = '0;
    end else begin
      flt_next = st_q.flt | flt_now;
    end
    st_d.flt = flt_next;
    st_d.rst_pulse = fw_reset_pulse;

    // ready relay sequencing
    case (st_q.rdy)
      sdi_pkg::SDI_RDY_WAIT_RST: begin
        st_d.relay = 1'b0;
        if (fw_reset_pulse && flt_now == '0) begin
          st_d.rdy = sdi_pkg::SDI_RDY_CLOSED;
          st_d.relay = 1'b1;
        end
      end
      sdi_pkg::SDI_RDY_CLOSED: begin
        st_d.relay = 1'b1;
        if (flt_now != '0) begin
          st_d.rdy = sdi_pkg::SDI_RDY_FAULT;
          st_d.relay = 1'b0;
        end
      end
      sdi_pkg::SDI_RDY_FAULT: begin
        st_d.relay = 1'b0;
        if (fw_reset_pulse && flt_now == '0) begin
          st_d.rdy = sdi_pkg::SDI_RDY_CLOSED;
          st_d.relay = 1'b1;
        end
      end
      default: begin
        st_d.rdy = sdi_pkg::SDI_RDY_WAIT_RST;
        st_d.relay = 1'b0;
      end
    endcase

    // power stage gate
    st_d.stage_en = hw_en_s && fw_enable && (flt_next == '0) &&
      (flt_now == '0);

    // commutation: six-step pattern per sector, reversed for negative torque
    case (sect)
      3'h0: pattern = 6'h21;
      3'h1: pattern = 6'h09;
      3'h2: pattern = 6'h0c;
      3'h3: pattern = 6'h06;
      3'h4: pattern = 6'h12;
      3'h5: pattern = 6'h30;
      default: pattern = '0;
    endcase
    if (torque_neg) begin
      pattern = {pattern[2:0], pattern[5:3]};
    end
    if (st_d.stage_en && torque_cmd != '0) begin
      st_d.sw = pattern;
    end else begin
      st_d.sw = '0;
    end

    // status flags
    st_d.mtemp = mtemp_s;
    st_d.dtemp = dtemp_s;

    // brake relay purely firmware driven
    st_d.brk_relay = fw_brake_relay;

    // dynamic brake follows the synchronised bus high indication directly, without hysteresis
    st_d.dbrake = bus_hi_s;
    if (fw_brake_time_clear) begin
      st_d.brk_time = '0;
    end
    if (bus_hi_s && st_q.brk_time != '1) begin
      st_d.brk_time = st_d.brk_time + 1'b1;
    end

    // indicators
    st_d.cpu_ok = fw_cpu_running;
    st_d.ind = fw_indicator;

    // fast event capture
    st_d.fev = fev_s;
  end

  //--------------------------------------------------------------
  // registers
  //--------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.rdy <= sdi_pkg::SDI_RDY_WAIT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  assign stage_enable = st_q.stage_en;
  assign switch_on = st_q.sw;
  assign ready_relay = st_q.relay;
  assign conv_reset_pulse = st_q.rst_pulse;
  assign motor_temp_high = st_q.mtemp;
  assign drive_temp_high = st_q.dtemp;
  assign fault_latched = st_q.flt;
  assign brake_relay = st_q.brk_relay;
  assign dyn_brake_on = st_q.dbrake;
  assign dyn_brake_time = st_q.brk_time;
  assign cpu_ok_led = st_q.cpu_ok;
  assign user_indicator = st_q.ind;
  assign fast_event_flag = st_q.fev;
endmodule // sdi_interlock

// ===== verification/sdi_checker.sv
// port checker for the servo drive fault interlock
`timescale 1ns/1ps
module sdi_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hw_enable_pin,
  input wire logic motor_temp_open_pin,
  input wire logic bus_overvolt_pin,
  input wire logic bus_high_pin,
  input wire logic fw_enable,
  input wire logic fw_soft_fault,
  input wire logic fw_brake_relay,
  input wire logic [sdi_pkg::IND_W-1:0] fw_indicator,
  input wire logic stage_enable,
  input wire logic ready_relay,
  input wire logic motor_temp_high,
  input wire logic [sdi_pkg::FLT_W-1:0] fault_latched,
  input wire logic brake_relay,
  input wire logic dyn_brake_on,
  input wire logic [sdi_pkg::IND_W-1:0] user_indicator
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_hw_low_off: assert property (
    !hw_enable_pin [*6] |-> !stage_enable)
    else $error("stage on with hw enable low");
  a_fw_off_gate: assert property (
    !fw_enable |=> !stage_enable)
    else $error("stage on without fw enable");
  // a latched fault already held the stage off on the edge that latched it
  a_fault_stage_off: assert property (
    |fault_latched |-> !stage_enable)
    else $error("stage on with latched fault");
  a_fault_relay_open: assert property (
    (|fault_latched) [*2] |-> !ready_relay)
    else $error("relay closed with latched fault");
  a_soft_relay_open: assert property (
    fw_soft_fault |-> ##[1:2] !ready_relay)
    else $error("relay closed on soft fault");
  a_brake_relay_fw: assert property (
    $changed(fw_brake_relay) |=> brake_relay == $past(fw_brake_relay))
    else $error("brake relay not following firmware");
  a_indicator_fw: assert property (
    !$past(sys_rst) |-> user_indicator == $past(fw_indicator))
    else $error("indicator not following firmware");
  a_motor_temp_flag: assert property (
    motor_temp_open_pin [*6] |-> motor_temp_high)
    else $error("motor temp flag missing");
  a_overvolt_trip: assert property (
    bus_overvolt_pin [*6] |-> fault_latched[sdi_pkg::FLT_OV])
    else $error("over-voltage fault missing");
  a_dyn_brake_follow: assert property (
    $stable(bus_high_pin) [*6] |-> dyn_brake_on == bus_high_pin)
    else $error("dynamic brake not following bus");
  // main scenarios seen
  c_stage_on: cover property (stage_enable);
  c_relay_close: cover property ($rose(ready_relay));
  c_dyn_brake: cover property (dyn_brake_on);
endmodule // sdi_checker

// ===== verification/sdi_conv_model.sv
// converter monitor model driving the fault and sensor pins
`timescale 1ns/1ps
module sdi_conv_model (
  input wire logic clk,
  input wire logic [5:0] req,
  input wire logic conv_reset_pulse,
  output logic [5:0] pins,
  output logic [7:0] rst_seen
);
  initial pins = 6'h00;
  initial rst_seen = 8'h00;
  // pins move just after an edge: temps, over-volt, supplies, bus high
  always @(posedge clk) pins <= req;
  // reset pulses arriving from the control side
  always @(posedge clk) if (conv_reset_pulse) rst_seen <= rst_seen + 8'h01;
endmodule // sdi_conv_model

// ===== verification/sdi_interlock_tb_top.sv
// self-checking testbench for the servo drive fault interlock
`timescale 1ns/1ps
module sdi_interlock_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hw_enable_pin = 1'b0;
  logic fast_event_input = 1'b0;
  logic [11:0] phase_current = 12'h000;
  logic [11:0] rated_peak_current = 12'h400;
  logic fw_enable = 1'b0;
  logic fw_soft_fault = 1'b0;
  logic fw_reset_pulse = 1'b0;
  logic fw_brake_relay = 1'b0;
  logic fw_cpu_running = 1'b0;
  logic [7:0] fw_indicator = 8'h00;
  logic fw_brake_time_clear = 1'b0;
  logic [11:0] motor_angle = 12'h000;
  logic [11:0] torque_cmd = 12'h000;
  logic torque_neg = 1'b0;
  logic [7:0] rst_cnt;
  logic [5:0] req = 6'h00;
  logic [5:0] pins;
  logic stage_enable, ready_relay, conv_reset_pulse, motor_temp_high;
  logic drive_temp_high, brake_relay, dyn_brake_on, cpu_ok_led;
  logic fast_event_flag;
  logic [5:0] switch_on;
  logic [4:0] fault_latched;
  logic [31:0] dyn_brake_time, t1, seed;
  logic [7:0] user_indicator;
  int error_cnt = 0;
  int tests_run = 0;
  // ----
  // clock, design and partner
  // ----
  initial forever #50 clk = ~clk;
  sdi_interlock i_dut (
    .clk(clk), .sys_rst(sys_rst), .hw_enable_pin(hw_enable_pin),
    .motor_temp_open_pin(pins[0]), .drive_temp_high_pin(pins[1]),
    .bus_overvolt_pin(pins[2]), .conv_logic_low_pin(pins[3]),
    .ctrl_logic_low_pin(pins[4]), .bus_high_pin(pins[5]),
    .fast_event_input(fast_event_input), .phase_current(phase_current),
    .rated_peak_current(rated_peak_current), .fw_enable(fw_enable),
    .fw_soft_fault(fw_soft_fault), .fw_reset_pulse(fw_reset_pulse),
    .fw_brake_relay(fw_brake_relay), .fw_cpu_running(fw_cpu_running),
    .fw_indicator(fw_indicator), .fw_brake_time_clear(fw_brake_time_clear),
    .motor_angle(motor_angle), .torque_cmd(torque_cmd),
    .torque_neg(torque_neg),
    .stage_enable(stage_enable), .switch_on(switch_on),
    .ready_relay(ready_relay), .conv_reset_pulse(conv_reset_pulse),
    .motor_temp_high(motor_temp_high), .drive_temp_high(drive_temp_high),
    .fault_latched(fault_latched), .brake_relay(brake_relay),
    .dyn_brake_on(dyn_brake_on), .dyn_brake_time(dyn_brake_time),
    .cpu_ok_led(cpu_ok_led), .user_indicator(user_indicator),
    .fast_event_flag(fast_event_flag)
  );
  sdi_conv_model i_conv (
    .clk(clk), .req(req), .conv_reset_pulse(conv_reset_pulse),
    .pins(pins), .rst_seen(rst_cnt)
  );
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // n edges, then look at the falling edge
  task automatic ws(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rst_pulse();
    @(posedge clk);
    fw_reset_pulse <= 1'b1;
    @(posedge clk);
    fw_reset_pulse <= 1'b0;
    @(negedge clk);
    chk(conv_reset_pulse, 1'b1);
    ws(1);
  endtask
  function automatic logic [4:0] exp_flt(input int k);
    exp_flt = 5'h01 << (k == 3 ? sdi_pkg::FLT_SW : sdi_pkg::FLT_OV + k);
  endfunction
  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    seed = 32'h0be9;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    ws(8);
    chk(ready_relay, 1'b0);
    rst_pulse();
    chk(ready_relay, 1'b1);
    // every pairing of hardware and firmware enable
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      hw_enable_pin <= i[1];
      fw_enable <= i[0];
      ws(6);
      chk(stage_enable, i[1] & i[0]);
    end
    chk(switch_on, 6'h00);
    @(posedge clk);
    torque_cmd <= 12'h100;
    ws(3);
    chk(|switch_on, 1'b1);
    // negative torque swaps the upper and lower switch groups
    t1 = switch_on;
    @(posedge clk);
    torque_neg <= 1'b1;
    ws(1);
    chk(switch_on, {t1[2:0], t1[5:3]});
    @(posedge clk);
    torque_neg <= 1'b0;
    // each fault kind except short-circuit latches, blocks reset while live, then clears
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      if (k == 3) fw_soft_fault <= 1'b1;
      else req[k + 2] <= 1'b1;
      ws(6);
      chk(fault_latched, exp_flt(k));
      chk(ready_relay, 1'b0);
      chk(stage_enable, 1'b0);
      rst_pulse();
      chk(ready_relay, 1'b0);
      @(posedge clk);
      fw_soft_fault <= 1'b0;
      req <= 6'h00;
      ws(6);
      chk(fault_latched, exp_flt(k));
      rst_pulse();
      chk(fault_latched, 5'h00);
      chk(ready_relay, 1'b1);
      ws(1);
      chk(stage_enable, 1'b1);
    end
    // temperature flags and the dynamic brake with its timer
    @(posedge clk);
    req <= 6'h23;
    ws(6);
    chk(motor_temp_high, 1'b1);
    chk(drive_temp_high, 1'b1);
    chk(dyn_brake_on, 1'b1);
    t1 = dyn_brake_time;
    ws(4);
    chk(dyn_brake_time - t1, 32'h4);
    @(posedge clk);
    fw_brake_time_clear <= 1'b1;
    ws(2);
    // clear restarts the count, the still active cycle counts again
    chk(dyn_brake_time, 32'h1);
    @(posedge clk);
    fw_brake_time_clear <= 1'b0;
    req <= 6'h00;
    ws(6);
    chk(dyn_brake_on, 1'b0);
    // brief over-current, far shorter than the persistence time
    @(posedge clk);
    phase_current <= 12'hc01;
    ws(20);
    chk(fault_latched, 5'h00);
    chk(stage_enable, 1'b1);
    // random firmware outputs with sub-threshold current
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      fw_indicator <= $random(seed);
      fw_brake_relay <= $random(seed);
      fw_cpu_running <= $random(seed);
      fast_event_input <= $random(seed);
      motor_angle <= $random(seed);
      phase_current <= $random(seed) & 12'h3ff;
      ws(1);
      chk(user_indicator, fw_indicator);
      chk(brake_relay, fw_brake_relay);
      chk(cpu_ok_led, fw_cpu_running);
      chk(fault_latched, 5'h00);
    end
    // one pulse at start plus two per tested fault kind reached the converter
    chk(rst_cnt, 8'h09);
    conclude();
  end
endmodule // sdi_interlock_tb_top
bind sdi_interlock sdi_checker i_chk (
  .clk(clk), .sys_rst(sys_rst), .hw_enable_pin(hw_enable_pin),
  .motor_temp_open_pin(motor_temp_open_pin),
  .bus_overvolt_pin(bus_overvolt_pin), .bus_high_pin(bus_high_pin),
  .fw_enable(fw_enable), .fw_soft_fault(fw_soft_fault),
  .fw_brake_relay(fw_brake_relay), .fw_indicator(fw_indicator),
  .stage_enable(stage_enable), .ready_relay(ready_relay),
  .motor_temp_high(motor_temp_high), .fault_latched(fault_latched),
  .brake_relay(brake_relay), .dyn_brake_on(dyn_brake_on),
  .user_indicator(user_indicator)
);
